/* File: logic/instruction_word_decoder.v */
// Decoder for 14-bit instruction words of an 8-bit core
// How it works
// - Whole 14-bit word fetched and decoded at once
// - Dest bit 0 selects accumulator, 1 register
// - Byte format: opcode 13:8, d 7, f 6:0
// - Bit format: opcode 13:10, bit 9:7, f
// - Literal format: opcode 13:8, literal 7:0
// - Call and jump: opcode 13:11, target 10:0
// - File address spans 7-bit range 00-7f
// - Instruction cycle equals four oscillator periods with CLK_EN high
// - Taken branch adds a second no-op cycle
// - File operand always read before written back
// - Don't-care bits masked for the no-op only; control words matched exactly
// - No-op pattern changes nothing but counter
// - Watchdog clear and sleep decoded, one cycle
`timescale 1ns/1ps
module instruction_word_decoder
(
   input  wire        REF_CLK,
   input  wire        SYS_RST,
   input  wire        CLK_EN,
   input  wire [13:0] INSTR_WORD,
   input  wire        COND_TRUE,
   output wire        FETCH_STROBE,
   output reg  [3:0]  OP_CLASS,
   output reg  [5:0]  OPCODE,
   output reg         DEST_FILE,
   output reg  [2:0]  BIT_NUM,
   output reg  [6:0]  FILE_ADDR,
   output reg  [7:0]  LITERAL,
   output reg  [10:0] JUMP_TARGET,
   output reg         FILE_READ,
   output reg         FILE_WRITE,
   output reg         ACC_WRITE,
   output reg         PC_LOAD,
   output reg         FLUSH_CYCLE,
   output reg         WATCHDOG_CLEAR_OP,
   output reg         SLEEP_OP,
   output reg         EXEC_STROBE
);
`include "decode_consts.vh"

   // -------------------------------------------------------------
   // Classification
   // -------------------------------------------------------------
   // The no-op mask drops its don't-care bits before comparing; other control words compare whole
   function [3:0] classify;
      input [13:0] w;
      begin
         classify = `CL_NOP;
         case (w[13:12])
            2'b00:
               if (w[11:8] != 4'h0)
               begin
                  if (w[11:8] == 4'hb || w[11:8] == 4'hf)
                     classify = `CL_SKIP_BYTE;
                  else
                     classify = `CL_BYTE;
               end
               else if (w[7])
                  classify = `CL_BYTE; // store accumulator to file
               else if ((w & `NOP_MASK) == `NOP_WORD)
                  classify = `CL_NOP;
               else if (w == `WDT_CLEAR_WORD)
                  classify = `CL_WDT_CLEAR;
               else if (w == `SLEEP_WORD)
                  classify = `CL_SLEEP;
               else if (w == `RETURN_WORD)
                  classify = `CL_RETURN;
               else if (w == `RETFIE_WORD)
                  classify = `CL_RETFIE;
               else
                  classify = `CL_NOP;
            2'b01:
               case (w[11:10])
                  2'b00:   classify = `CL_BIT_CLR;
                  2'b01:   classify = `CL_BIT_SET;
                  2'b10:   classify = `CL_BIT_TSTC;
                  default: classify = `CL_BIT_TSTS;
               endcase
            2'b10:
               classify = w[11] ? `CL_JUMP : `CL_CALL;
            default:
               if (w[11:10] == 2'b01)
                  classify = `CL_RETLW;
               else if (w[11:8] == 4'hb)
                  classify = `CL_NOP;
               else
                  classify = `CL_LIT;
         endcase
      end
   endfunction

   // -------------------------------------------------------------
   // Cycle timing
   // -------------------------------------------------------------
   wire [1:0] phase;
   wire       phase_last;

   cycle_phase u_phase
   (
      .clk       (REF_CLK),
      .rst       (SYS_RST),
      .ce        (CLK_EN),
      .phase_reg (phase),
      .last      (phase_last)
   );

   // One fetch per four oscillator periods with CLK_EN high
   assign FETCH_STROBE = CLK_EN & phase_last;

   reg  [13:0] word_reg;
   reg         flush_reg;
   wire [3:0]  cls = classify(word_reg);
   wire        is_file = (cls == `CL_BYTE) || (cls == `CL_SKIP_BYTE) ||
                         (cls == `CL_BIT_CLR) || (cls == `CL_BIT_SET) ||
                         (cls == `CL_BIT_TSTC) || (cls == `CL_BIT_TSTS);
   wire        is_pc = (cls == `CL_CALL) || (cls == `CL_JUMP) ||
                       (cls == `CL_RETURN) || (cls == `CL_RETFIE) ||
                       (cls == `CL_RETLW);
   wire        is_test = (cls == `CL_SKIP_BYTE) ||
                         (cls == `CL_BIT_TSTC) || (cls == `CL_BIT_TSTS);
   wire        run = ~flush_reg;

   // -------------------------------------------------------------
   // Latch word and flush state
   // -------------------------------------------------------------
   always @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         word_reg  <= `RESET_WORD;
         flush_reg <= 1'b0;
      end
      else if (FETCH_STROBE)
      begin
         word_reg  <= INSTR_WORD;
         // Branch taken: the next fetched word runs as a no-op
         flush_reg <= run & (is_pc | (is_test & COND_TRUE));
      end
   end

   // -------------------------------------------------------------
   // Decoded outputs, registered
   // -------------------------------------------------------------
   always @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         OP_CLASS          <= `CL_NOP;
         OPCODE            <= 6'h00;
         DEST_FILE         <= 1'b0;
         BIT_NUM           <= 3'h0;
         FILE_ADDR         <= `FILE_ADDR_MIN;
         LITERAL           <= 8'h00;
         JUMP_TARGET       <= 11'h000;
         FILE_READ         <= 1'b0;
         FILE_WRITE        <= 1'b0;
         ACC_WRITE         <= 1'b0;
         PC_LOAD           <= 1'b0;
         FLUSH_CYCLE       <= 1'b0;
         WATCHDOG_CLEAR_OP <= 1'b0;
         SLEEP_OP          <= 1'b0;
         EXEC_STROBE       <= 1'b0;
      end
      else if (CLK_EN)
      begin
         EXEC_STROBE <= phase_last;
         if (phase == 2'h0)
         begin
            // Flushed cycle reports a no-op and no side effects
            OP_CLASS    <= run ? cls : `CL_NOP;
            FLUSH_CYCLE <= flush_reg;
            if (cls == `CL_CALL || cls == `CL_JUMP)
               OPCODE <= {3'h0, word_reg[`BYTE_OP_HI:`JMP_OP_LO]};
            else if (cls == `CL_BIT_CLR || cls == `CL_BIT_SET ||
                     cls == `CL_BIT_TSTC || cls == `CL_BIT_TSTS)
               OPCODE <= {2'h0, word_reg[`BYTE_OP_HI:`BIT_OP_LO]};
            else
               OPCODE <= word_reg[`BYTE_OP_HI:`BYTE_OP_LO];
            DEST_FILE   <= word_reg[`DEST_BIT];
            BIT_NUM     <= word_reg[`BITNUM_HI:`BITNUM_LO];
            // Seven bits cover the whole direct space 00-7f
            FILE_ADDR   <= word_reg[`FILE_HI:`FILE_LO];
            LITERAL     <= word_reg[`LIT_HI:0];
            JUMP_TARGET <= word_reg[`JMP_HI:0];
            // Read happens for every file op not flushed, even write-only ones
            FILE_READ   <= run & is_file;
            FILE_WRITE  <= 1'b0;
            ACC_WRITE   <= 1'b0;
            PC_LOAD     <= run & is_pc;
            WATCHDOG_CLEAR_OP <= run & (cls == `CL_WDT_CLEAR);
            SLEEP_OP          <= run & (cls == `CL_SLEEP);
         end
         else if (phase == 2'h2)
         begin
            FILE_READ <= 1'b0;
            // Write back strictly after the read phase
            FILE_WRITE <= run & ((cls == `CL_BYTE && word_reg[`DEST_BIT])
                          || cls == `CL_BIT_CLR || cls == `CL_BIT_SET
                          || (cls == `CL_SKIP_BYTE
                              && word_reg[`DEST_BIT]));
            ACC_WRITE  <= run & (((cls == `CL_BYTE || cls == `CL_SKIP_BYTE)
                          && !word_reg[`DEST_BIT])
                          || cls == `CL_LIT || cls == `CL_RETLW);
         end
      end
   end
endmodule // instruction_word_decoder

/* File: logic/decode_consts.vh */
// Field positions, encodings and timing counts for the instruction decoder
`ifndef DECODE_CONSTS_VH
`define DECODE_CONSTS_VH

`define IW_WIDTH        14
`define BYTE_OP_HI      13
`define BYTE_OP_LO      8
`define DEST_BIT        7
`define FILE_HI         6
`define FILE_LO         0
`define BIT_OP_LO       10
`define BITNUM_HI       9
`define BITNUM_LO       7
`define LIT_HI          7
`define JMP_OP_LO       11
`define JMP_HI          10
`define FILE_ADDR_MIN   7'h00
`define FILE_ADDR_MAX   7'h7f
`define OSC_PER_CYCLE   3'h4
`define PH_LAST         2'h3
`define RESET_WORD      14'h0000
`define NOP_MASK        14'h3f9f
`define NOP_WORD        14'h0000
`define WDT_CLEAR_WORD  14'h0064
`define SLEEP_WORD      14'h0063
`define RETURN_WORD     14'h0008
`define RETFIE_WORD     14'h0009

// Operation classes
`define CL_NOP          4'h0
`define CL_BYTE         4'h1
`define CL_BIT_CLR      4'h2
`define CL_BIT_SET      4'h3
`define CL_BIT_TSTC     4'h4
`define CL_BIT_TSTS     4'h5
`define CL_LIT          4'h6
`define CL_CALL         4'h7
`define CL_JUMP         4'h8
`define CL_RETURN       4'h9
`define CL_RETFIE       4'ha
`define CL_RETLW        4'hb
`define CL_WDT_CLEAR    4'hc
`define CL_SLEEP        4'hd
`define CL_SKIP_BYTE    4'he

`endif

/* File: logic/cycle_phase.v */
// Four-period instruction cycle phase counter
`timescale 1ns/1ps
module cycle_phase
(
   input  wire       clk,
   input  wire       rst,
   input  wire       ce,
   output reg  [1:0] phase_reg,
   output wire       last
);
`include "decode_consts.vh"

   assign last = (phase_reg == `PH_LAST);

   always @(posedge clk)
   begin
      if (rst)
         phase_reg <= 2'h0;
      else if (ce)
         phase_reg <= phase_reg + 2'h1;
   end
endmodule // cycle_phase

/* File: testbench/iwd_checker.sv */
// Assertion checker for the instruction word decoder ports
`timescale 1ns/1ps
`include "decode_consts.vh"
module iwd_checker
(
   input wire       REF_CLK,
   input wire       SYS_RST,
   input wire       CLK_EN,
   input wire       FETCH_STROBE,
   input wire [3:0] OP_CLASS,
   input wire       DEST_FILE,
   input wire       FILE_READ,
   input wire       FILE_WRITE,
   input wire       ACC_WRITE,
   input wire       PC_LOAD,
   input wire       FLUSH_CYCLE,
   input wire       WATCHDOG_CLEAR_OP,
   input wire       SLEEP_OP
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   //----------------------------------------------------------------
   // Properties
   //----------------------------------------------------------------
   a_fetch_period: assert property (FETCH_STROBE ##1
      (CLK_EN && !FETCH_STROBE)[*3] ##1 CLK_EN |-> FETCH_STROBE)
      else $error("fetch spacing wrong");
   a_read_first: assert property ($rose(FILE_WRITE) |->
      $past(FILE_READ)) else $error("write without prior read");
   a_dest_select: assert property (OP_CLASS == `CL_BYTE &&
      (FILE_WRITE || ACC_WRITE) |-> FILE_WRITE == DEST_FILE &&
      ACC_WRITE != DEST_FILE) else $error("wrong destination");
   a_nop_quiet: assert property (OP_CLASS == `CL_NOP |->
      !(FILE_WRITE || ACC_WRITE || PC_LOAD || FILE_READ))
      else $error("no-op has effect");
   a_branch_load: assert property (FETCH_STROBE && OP_CLASS inside
      {`CL_CALL, `CL_JUMP, `CL_RETURN, `CL_RETFIE, `CL_RETLW}
      |-> PC_LOAD) else $error("branch without counter load");
   a_flush_next: assert property (FETCH_STROBE && PC_LOAD |=>
      ##[0:40] FLUSH_CYCLE) else $error("no flush after branch");
   a_flush_quiet: assert property (FLUSH_CYCLE |-> !(PC_LOAD ||
      FILE_WRITE || ACC_WRITE || WATCHDOG_CLEAR_OP || SLEEP_OP))
      else $error("flush cycle has effect");
   a_ctrl_class: assert property (WATCHDOG_CLEAR_OP || SLEEP_OP |->
      OP_CLASS == (SLEEP_OP ? `CL_SLEEP : `CL_WDT_CLEAR))
      else $error("control strobe class wrong");
   a_enable_hold: assert property (!CLK_EN |=> $stable(OP_CLASS) &&
      $stable(FILE_WRITE) && $stable(PC_LOAD)) else $error("not frozen");
   c_flush: cover property (FLUSH_CYCLE);
   c_write: cover property (FILE_WRITE);
   c_sleep: cover property (SLEEP_OP);
endmodule // iwd_checker
bind instruction_word_decoder iwd_checker i_chk
(
   .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
   .FETCH_STROBE(FETCH_STROBE), .OP_CLASS(OP_CLASS),
   .DEST_FILE(DEST_FILE), .FILE_READ(FILE_READ),
   .FILE_WRITE(FILE_WRITE), .ACC_WRITE(ACC_WRITE), .PC_LOAD(PC_LOAD),
   .FLUSH_CYCLE(FLUSH_CYCLE), .WATCHDOG_CLEAR_OP(WATCHDOG_CLEAR_OP),
   .SLEEP_OP(SLEEP_OP)
);

/* File: testbench/prog_mem_model.sv */
// Program memory model feeding instruction words
`timescale 1ns/1ps
module prog_mem_model
(
   input  wire        clk,
   input  wire        rst,
   input  wire        fetch,
   output reg  [13:0] word
);
   reg [13:0] mem [0:255];
   reg [7:0]  pc = 8'h00;
   initial
      word = 14'h0000;
   // Word moves only at the falling edge, so it is steady at fetch
   always @(posedge clk)
      pc <= rst ? 8'h00 : pc + {7'h00, fetch};
   always @(negedge clk)
      word <= mem[pc];
endmodule // prog_mem_model

/* File: testbench/instruction_word_decoder_tb.sv */
// Self-checking bench for the instruction word decoder
`timescale 1ns/1ps
`include "decode_consts.vh"
module instruction_word_decoder_tb;
   localparam [223:0] DIR = {14'h0000, 14'h0060, 14'h0064, 14'h0063,
      14'h07ff, 14'h0700, 14'h3fa5, 14'h1fff, 14'h2fff, 14'h2000,
      14'h3b55, 14'h3455, 14'h0008, 14'h0009, 14'h0bff, 14'h0a12};
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         en = 1'b1;
   reg         cond = 1'b0;
   wire [13:0] word;
   wire        fs, dst, pcl, fl, wdc, slp;
   wire        fr, fw, aw, ex;
   reg         fr_seen = 1'b0;
   reg         ex_seen = 1'b0;
   wire [3:0]  cls;
   wire [5:0]  opc;
   wire [2:0]  bn;
   wire [6:0]  fa;
   wire [7:0]  lit;
   wire [10:0] jt;
   integer     err_total = 0;
   integer     n_compared = 0;
   integer     k = 0;
   integer     i;
   reg [31:0]  r;
   reg [13:0]  w;
   reg [3:0]   c;
   reg         fl_cur = 1'b0;
   initial
      forever #2.5 clk = ~clk;
   prog_mem_model i_mem (.clk(clk), .rst(rst), .fetch(fs), .word(word));
   instruction_word_decoder i_dut (.REF_CLK(clk), .SYS_RST(rst),
      .CLK_EN(en), .INSTR_WORD(word), .COND_TRUE(cond),
      .FETCH_STROBE(fs), .OP_CLASS(cls), .OPCODE(opc), .DEST_FILE(dst),
      .BIT_NUM(bn), .FILE_ADDR(fa), .LITERAL(lit), .JUMP_TARGET(jt),
      .FILE_READ(fr), .FILE_WRITE(fw), .ACC_WRITE(aw), .PC_LOAD(pcl),
      .FLUSH_CYCLE(fl), .WATCHDOG_CLEAR_OP(wdc), .SLEEP_OP(slp),
      .EXEC_STROBE(ex));
   function [3:0] ecls(input [13:0] x);
      case (x[13:12])
         2'b10: ecls = x[11] ? `CL_JUMP : `CL_CALL;
         2'b01: ecls = `CL_BIT_CLR + {2'b00, x[11:10]};
         2'b11: ecls = x[11:8] == 4'hb ? `CL_NOP :
            x[11:10] == 2'b01 ? `CL_RETLW : `CL_LIT;
         default: ecls = x[11:8] == 4'hb || x[11:8] == 4'hf ?
            `CL_SKIP_BYTE : x[11:7] != 5'h00 ? `CL_BYTE :
            x == 14'h0064 ? `CL_WDT_CLEAR : x == 14'h0063 ? `CL_SLEEP :
            x == 14'h0008 ? `CL_RETURN : x == 14'h0009 ? `CL_RETFIE :
            `CL_NOP;
      endcase
   endfunction
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp)
         begin
            err_total = err_total + 1;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
         end
      end
   endtask
   //----------------------------------------------------------------
   // Reference model, checked at every fetch after the first
   //----------------------------------------------------------------
   always @(negedge clk)
   begin
      r = $urandom;
      en = r[1:0] != 2'b00;
      #1;
      // Read and execute pulses stand only briefly, so latch them
      if (fr)
         fr_seen = 1'b1;
      if (ex)
         ex_seen = 1'b1;
      if (rst)
      begin
         k = 0;
         fl_cur = 1'b0;
         fr_seen = 1'b0;
         ex_seen = 1'b0;
      end
      else if (fs)
      begin
         w = k > 0 ? i_mem.mem[k - 1] : 14'h0000;
         c = fl_cur ? `CL_NOP : ecls(w);
         if (k > 0 && fl_cur)
            chk({fl, pcl}, 2'b10);
         else if (k > 0)
         begin
            chk(cls, c);
            chk({fl, pcl}, {1'b0, c inside {`CL_CALL, `CL_JUMP,
               `CL_RETURN, `CL_RETFIE, `CL_RETLW}});
            chk({wdc, slp}, {c == `CL_WDT_CLEAR, c == `CL_SLEEP});
            if (c == `CL_BYTE || c == `CL_SKIP_BYTE)
               chk({opc, dst, fa}, w);
            if (c >= `CL_BIT_CLR && c <= `CL_BIT_TSTS)
               chk({opc, bn, fa}, {2'b00, w});
            if (c == `CL_LIT || c == `CL_RETLW)
               chk({opc, lit}, w);
            if (c == `CL_CALL || c == `CL_JUMP)
               chk({opc, jt}, {3'b000, w});
         end
         if (k > 0)
         begin
            chk({fr_seen, ex_seen}, {c inside {`CL_BYTE, `CL_SKIP_BYTE,
               `CL_BIT_CLR, `CL_BIT_SET, `CL_BIT_TSTC, `CL_BIT_TSTS},
               1'b1});
            chk({fw, aw}, {((c == `CL_BYTE || c == `CL_SKIP_BYTE) && w[7])
               || c == `CL_BIT_CLR || c == `CL_BIT_SET,
               ((c == `CL_BYTE || c == `CL_SKIP_BYTE) && !w[7])
               || c == `CL_LIT || c == `CL_RETLW});
         end
         fr_seen = 1'b0;
         ex_seen = 1'b0;
         cond = r[2];
         fl_cur = c inside {`CL_CALL, `CL_JUMP, `CL_RETURN, `CL_RETFIE,
            `CL_RETLW} || (cond && c inside {`CL_BIT_TSTC, `CL_BIT_TSTS,
            `CL_SKIP_BYTE});
         k = k + 1;
      end
   end
   task run(input integer n, input integer rnd);
      begin
         rst <= 1'b1;
         @(negedge clk);
         for (i = 0; i < 256; i = i + 1)
         begin
            r = $urandom;
            i_mem.mem[i] = rnd ? r[13:0] : DIR[(i % 16) * 14 +: 14];
         end
         repeat (4) @(negedge clk);
         rst <= 1'b0;
         repeat (n) @(negedge clk);
         $display("test done after %0d fetches", k);
      end
   endtask
   task summarize;
      begin
         $display("compared %0d mismatches %0d", n_compared, err_total);
         if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial
   begin
      #30000;
      err_total = err_total + 1;
      summarize;
   end
   initial
   begin
      r = $urandom(26);
      run(300, 0);
      run(900, 1);
      run(150, 1);
      summarize;
   end
endmodule // instruction_word_decoder_tb
